/* common/tms_consts.vh */
// constants for the target mailbox signalling block
`ifndef TMS_CONSTS_VH
`define TMS_CONSTS_VH
// register byte offsets
`define TMS_REG_CFG 8'h00
`define TMS_REG_APPLIED 8'h04
`define TMS_REG_SIGCTL 8'h08
`define TMS_REG_CMD 8'h0C
`define TMS_REG_TXDATA 8'h10
`define TMS_REG_SRCADDR 8'h14
`define TMS_REG_SRCPORT 8'h18
`define TMS_REG_RXDATA 8'h1C
`define TMS_REG_DSTADDR 8'h20
`define TMS_REG_DSTPORT 8'h24
`define TMS_REG_MEMSET 8'h28
`define TMS_REG_IRQSTAT 8'h2C
`define TMS_REG_IRQMASK 8'h30
// configuration fields
`define TMS_CFG_RACNT 2:0
`define TMS_CFG_WREQ 3
`define TMS_CFG_SRCHDR 4
`define TMS_CFG_DBGDP 5
`define TMS_CFG_CONSRA 6
`define TMS_CFG_DBGRA 7
`define TMS_CFG_W 8
`define TMS_CFG_RST 8'h01
// signal control fields
`define TMS_SIG_MODE 1:0
`define TMS_SIG_LEVEL 2
`define TMS_SIG_ACKGATE 3
`define TMS_SIG_IVAL 31:16
`define TMS_MODE_LEVEL 2'h0
`define TMS_MODE_PERIODIC 2'h1
`define TMS_MODE_PULSE 2'h2
`define TMS_MODE_DREADY 2'h3
// command bits
`define TMS_CMD_TGTRST 0
`define TMS_CMD_PKTSTART 1
`define TMS_CMD_NOTIFY 2
// target address regions of the interrupt area
`define TMS_AREA_REGION 9:8
`define TMS_AREA_CONS 2'h0
`define TMS_AREA_DBG 2'h1
`define TMS_AREA_MEMSET 2'h2
`define TMS_AREA_CTRL 2'h3
`define TMS_CTRL_ACK 8'h00
`define TMS_CTRL_SOP 8'h01
// interrupt bits
`define TMS_IRQ_RX 0
`define TMS_IRQ_MEMSET 1
`define TMS_IRQ_ACK 2
`define TMS_IRQ_HDR 3
`define TMS_IRQ_W 4
// timing and byte counts
`define TMS_TICK_MS 16'h0005
`define TMS_CLK_KHZ 100000
`define TMS_HDR_BYTES 3'h6
`define TMS_MEMSET_BYTES 2'h3
`endif

/* testbench/target_mailbox_signalling_tb_top.sv */
// self-checking bench of the target mailbox signalling core
`timescale 1ns/100ps
`include "tms_consts.vh"
module target_mailbox_signalling_tb_top;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg wbCyc = 1'b0;
  reg wbStb = 1'b0;
  reg wbWe = 1'b0;
  reg [7:0] wbAdr = 8'h00;
  reg [31:0] wbDat = 32'h0;
  wire [31:0] wbDatO;
  wire wbAck, ctlOut, ctlOe, tgtRstOut, tgtRstOe, mbxValid, emuWrStb, irq, tgtReadN;
  wire [7:0] mbxData, emuWrData;
  wire [15:0] emuWrAddr;
  wire [9:0] tgtAddr;
  integer mismatches = 0;
  integer n_tests = 0;
  integer seed = 47241;
  integer i;
  reg [31:0] qRd[$];
  reg [7:0] qMbx[$];
  reg [23:0] qEmu[$];
  reg [31:0] rA, cfg, prev;
  reg [15:0] rP;
  always #5 clk = ~clk;
  tms_core #(.TICK_CYCLES(20), .RST_CYCLES(10)) i_tms_core (.clk(clk), .reset_n(reset_n),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
    .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .tgtReadN(tgtReadN),
    .tgtAddr(tgtAddr), .ctlOut(ctlOut), .ctlOe(ctlOe), .tgtRstOut(tgtRstOut),
    .tgtRstOe(tgtRstOe), .mbxData(mbxData), .mbxValid(mbxValid), .emuWrStb(emuWrStb),
    .emuWrAddr(emuWrAddr), .emuWrData(emuWrData), .irq(irq));
  tms_target_model i_tms_target_model (.clk(clk), .tgtReadN(tgtReadN), .tgtAddr(tgtAddr));
  task cmpVal(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task test_done;
    begin
      if (qRd.size() + qMbx.size() + qEmu.size() != 0) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED pending results expected 0 seen %0d",
          qRd.size() + qMbx.size() + qEmu.size());
      end
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // results are compared in order against the oldest note
  always @(posedge clk) begin
    if (wbAck === 1'b1 && wbWe === 1'b0)
      cmpVal("read data", qRd.size() ? qRd.pop_front() : 32'hXXXXXXXX, wbDatO);
    if (emuWrStb === 1'b1)
      cmpVal("memory set", qEmu.size() ? qEmu.pop_front() : 32'hXXXXXXXX,
        {8'h00, emuWrAddr, emuWrData});
    if (mbxValid === 1'b1)
      cmpVal("mailbox", qMbx.size() ? qMbx.pop_front() : 32'hXXXXXXXX, mbxData);
  end
  task wb(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDat <= d;
      @(posedge clk);
      while (wbAck !== 1'b1) begin
        @(posedge clk);
      end
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
    end
  endtask
  task wbRd(input [7:0] a, input [31:0] e);
    begin
      qRd.push_back(e);
      wb(a, 1'b0, 32'h0);
    end
  endtask
  task tgtReset;
    begin
      wb(`TMS_REG_CMD, 1'b1, 32'h1);
      repeat (2) @(posedge clk);
      while (tgtRstOe === 1'b1) begin
        @(posedge clk);
      end
    end
  endtask
  task memset(input [23:0] m, input integer n);
    begin
      qEmu.push_back(m);
      i_tms_target_model.rdByte(`TMS_AREA_MEMSET, m[23:16], n);
      i_tms_target_model.rdByte(`TMS_AREA_MEMSET, m[15:8], n);
      i_tms_target_model.rdByte(`TMS_AREA_MEMSET, m[7:0], n);
      repeat (6) @(posedge clk);
    end
  endtask
  task pkt(input h);
    reg [47:0] hd;
    integer k;
    begin
      hd = {rA, rP};
      for (k = 0; k < 6 && h; k = k + 1)
        qMbx.push_back(hd[47 - 8 * k -: 8]);
      wb(`TMS_REG_CMD, 1'b1, 32'h2);
      qMbx.push_back(8'h5A);
      wb(`TMS_REG_TXDATA, 1'b1, 32'h5A);
      repeat (4) @(posedge clk);
    end
  endtask
  task sig(input integer d, input e);
    begin
      repeat (d) @(posedge clk);
      #1;
      cmpVal("control output", e, ctlOe);
    end
  endtask
  task irqAt(input e);
    begin
      repeat (3) @(posedge clk);
      #1;
      cmpVal("irq", e, irq);
    end
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    mismatches = mismatches + 1;
    test_done;
  end
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    wbRd(`TMS_REG_CFG, 32'h01);
    wbRd(8'h3C, 32'h0);
    prev = 32'h01;
    for (i = 0; i < 3; i = i + 1) begin
      cfg = (32'h1 << i) | 32'h08;
      wb(`TMS_REG_CFG, 1'b1, cfg);
      wbRd(`TMS_REG_APPLIED, prev);
      tgtReset;
      wbRd(`TMS_REG_APPLIED, cfg);
      memset($random(seed), 1 << i);
      prev = cfg;
    end
    wb(`TMS_REG_IRQSTAT, 1'b1, 32'hF);
    wb(`TMS_REG_IRQMASK, 1'b1, 32'h2);
    irqAt(1'b0);
    memset($random(seed), 4);
    irqAt(1'b1);
    wb(`TMS_REG_IRQSTAT, 1'b1, 32'h2);
    irqAt(1'b0);
    wb(`TMS_REG_IRQMASK, 1'b1, 32'h0);
    memset($random(seed), 4);
    irqAt(1'b0);
    wb(`TMS_REG_IRQMASK, 1'b1, 32'h2);
    irqAt(1'b1);
    wb(`TMS_REG_IRQSTAT, 1'b1, 32'h2);
    irqAt(1'b0);
    rA = $random(seed);
    rP = $random(seed);
    wb(`TMS_REG_SRCADDR, 1'b1, rA);
    wb(`TMS_REG_SRCPORT, 1'b1, {16'h0, rP});
    wb(`TMS_REG_CFG, 1'b1, 32'hB2);
    pkt(1'b0);
    tgtReset;
    pkt(1'b1);
    i_tms_target_model.sendHdr(~rA, ~rP, 2);
    wbRd(`TMS_REG_DSTADDR, ~rA);
    wbRd(`TMS_REG_DSTPORT, {16'h0, ~rP});
    i_tms_target_model.rdByte(`TMS_AREA_DBG, 8'hC3, 2);
    repeat (4) @(posedge clk);
    wbRd(`TMS_REG_RXDATA, 32'hC3);
    wb(`TMS_REG_CFG, 1'b1, 32'h92);
    tgtReset;
    pkt(1'b0);
    wb(`TMS_REG_SIGCTL, 1'b1, 32'h4);
    sig(3, 1'b1);
    wb(`TMS_REG_SIGCTL, 1'b1, 32'h0);
    sig(3, 1'b0);
    wb(`TMS_REG_SIGCTL, 1'b1, 32'h6);
    sig(3, 1'b1);
    sig(15, 1'b1);
    sig(7, 1'b0);
    wb(`TMS_REG_SIGCTL, 1'b1, 32'h000C0005);
    sig(5, 1'b1);
    sig(45, 1'b0);
    sig(40, 1'b1);
    wb(`TMS_REG_SIGCTL, 1'b1, 32'h0);
    sig(3, 1'b0);
    sig(80, 1'b0);
    wb(`TMS_REG_SIGCTL, 1'b1, 32'hF);
    wb(`TMS_REG_CMD, 1'b1, 32'h4);
    sig(3, 1'b1);
    sig(22, 1'b0);
    wb(`TMS_REG_CMD, 1'b1, 32'h4);
    sig(3, 1'b0);
    i_tms_target_model.rdByte(`TMS_AREA_CTRL, `TMS_CTRL_ACK, 2);
    qMbx.push_back(8'h11);
    wb(`TMS_REG_TXDATA, 1'b1, 32'h11);
    sig(3, 1'b1);
    repeat (30) @(posedge clk);
    test_done;
  end
endmodule

/* testbench/tms_core_checker.sv */
// assertions on the ports of the mailbox signalling core
`timescale 1ns/100ps
`include "tms_consts.vh"
module tms_core_checker (
  input wire clk,
  input wire reset_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire ctlOut,
  input wire ctlOe,
  input wire tgtRstOut,
  input wire tgtRstOe,
  input wire mbxValid,
  input wire emuWrStb,
  input wire irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire wrDone = wb_ack_o && wb_we_i;
  wire rstCmd = wrDone && wb_adr_i == `TMS_REG_CMD && wb_dat_i[0];
  wire sigWr = wrDone && wb_adr_i == `TMS_REG_SIGCTL && wb_sel_i[0];
  reg lvl;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      lvl <= 1'b0;
    else if (sigWr)
      lvl <= wb_dat_i[2];
  end
  property p_ackPulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
  property p_ackReq; wb_ack_o |-> wb_cyc_i && wb_stb_i; endproperty
  a_ackReq: assert property (p_ackReq) else $error("ack without request");
  property p_openDrain; ctlOut == 1'b0 && tgtRstOut == 1'b0; endproperty
  a_openDrain: assert property (p_openDrain) else $error("pin data not low");
  property p_level;
    sigWr && wb_dat_i[`TMS_SIG_MODE] == `TMS_MODE_LEVEL |-> ##[1:3] ctlOe == lvl;
  endproperty
  a_level: assert property (p_level) else $error("level request not applied");
  property p_pulse;
    sigWr && wb_dat_i[`TMS_SIG_MODE] == `TMS_MODE_PULSE |-> ##3 (ctlOe == lvl) [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too short");
  property p_memsetPulse; emuWrStb |=> !emuWrStb; endproperty
  a_memsetPulse: assert property (p_memsetPulse) else $error("memory set strobe long");
  property p_txPlaced;
    wrDone && wb_adr_i == `TMS_REG_TXDATA |-> ##[0:2] mbxValid;
  endproperty
  a_txPlaced: assert property (p_txPlaced) else $error("byte not placed");
  property p_rstStart;
    $rose(tgtRstOe) |-> rstCmd || $past(rstCmd) || $past(rstCmd, 2);
  endproperty
  a_rstStart: assert property (p_rstStart) else $error("target reset uncommanded");
  property p_irqFall;
    $fell(irq) |-> wrDone || $past(wrDone) || $past(wrDone, 2);
  endproperty
  a_irqFall: assert property (p_irqFall) else $error("irq fell without write");
endmodule
bind tms_core tms_core_checker i_tms_core_checker (.clk(clk), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .ctlOut(ctlOut),
  .ctlOe(ctlOe), .tgtRstOut(tgtRstOut), .tgtRstOe(tgtRstOe), .mbxValid(mbxValid),
  .emuWrStb(emuWrStb), .irq(irq));

/* testbench/tms_target_model.sv */
// target processor model reading the interrupt area of pod 0
`timescale 1ns/100ps
`include "tms_consts.vh"
module tms_target_model (
  input wire clk,
  output reg tgtReadN,
  output reg [9:0] tgtAddr
);
  initial begin
    tgtReadN = 1'b1;
    tgtAddr = 10'h3FF;
  end
  // value sent as the address read, repeated n times per byte
  task rdByte(input [1:0] rg, input [7:0] val, input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        @(posedge clk);
        tgtAddr <= {rg, val};
        repeat (2) @(posedge clk);
        tgtReadN <= 1'b0;
        repeat (4) @(posedge clk);
        tgtReadN <= 1'b1;
        repeat (2) @(posedge clk);
        tgtAddr <= ~{rg, val};
        repeat (2) @(posedge clk);
      end
    end
  endtask
  // start of packet, then address and port most significant byte first
  task sendHdr(input [31:0] a, input [15:0] p, input integer n);
    reg [47:0] h;
    integer k;
    begin
      h = {a, p};
      rdByte(`TMS_AREA_CTRL, `TMS_CTRL_SOP, n);
      for (k = 0; k < 6; k = k + 1)
        rdByte(`TMS_AREA_DBG, h[47 - 8 * k -: 8], n);
    end
  endtask
endmodule

/* verilog/tms_core.v */
// target mailbox signalling: read counting, memory set, control output, source header
`timescale 1ns/100ps
`include "tms_consts.vh"

module tms_core #(
  parameter TICK_CYCLES = `TMS_TICK_MS * `TMS_CLK_KHZ,
  parameter RST_CYCLES = `TMS_TICK_MS * `TMS_CLK_KHZ
) (
  input wire clk,
  input wire reset_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire tgtReadN,
  input wire [9:0] tgtAddr,
  output reg ctlOut,
  output reg ctlOe,
  output reg tgtRstOut,
  output reg tgtRstOe,
  output reg [7:0] mbxData,
  output reg mbxValid,
  output reg emuWrStb,
  output reg [15:0] emuWrAddr,
  output reg [7:0] emuWrData,
  output reg irq
);

  // ==========================================================================
  // functions
  function [31:0] byteMerge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] sel;
    integer i;
    begin
      byteMerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          byteMerge[i*8 +: 8] = din[i*8 +: 8];
        end
      end
    end
  endfunction

  function [15:0] msToSteps;
    input [15:0] ms;
    begin
      msToSteps = ms / `TMS_TICK_MS;
    end
  endfunction

  // ==========================================================================
  // registers
  reg [`TMS_CFG_W-1:0] cfg_reg;
  reg [`TMS_CFG_W-1:0] applied_reg;
  reg [31:0] sigCtl_reg;
  reg [15:0] steps_reg;
  reg [31:0] srcAddr_reg;
  reg [15:0] srcPort_reg;
  reg [7:0] rxData_reg;
  reg [31:0] dstAddr_reg;
  reg [15:0] dstPort_reg;
  reg [`TMS_IRQ_W-1:0] irqStat_reg;
  reg [`TMS_IRQ_W-1:0] irqMask_reg;

  wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  reg [2:0] hdrTxCnt_reg;
  wire txStall = (wb_adr_i == `TMS_REG_TXDATA) && (hdrTxCnt_reg != 3'h0);
  wire wbTake = wbReq & ~(wb_we_i & txStall);
  wire wrTake = wbTake & wb_we_i;
  wire cmdWr = wrTake && (wb_adr_i == `TMS_REG_CMD);
  wire tgtRstCmd = cmdWr & wb_sel_i[0] & wb_dat_i[`TMS_CMD_TGTRST];
  wire pktStart = cmdWr & wb_sel_i[0] & wb_dat_i[`TMS_CMD_PKTSTART];
  wire notifyCmd = cmdWr & wb_sel_i[0] & wb_dat_i[`TMS_CMD_NOTIFY];
  wire txWr = wrTake && (wb_adr_i == `TMS_REG_TXDATA) && wb_sel_i[0];
  wire sigWr = wrTake && (wb_adr_i == `TMS_REG_SIGCTL);
  wire [31:0] sigNext = byteMerge(sigCtl_reg, wb_dat_i, wb_sel_i);
  wire [31:0] cfgMerge = byteMerge({24'h000000, cfg_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] portMerge = byteMerge({16'h0000, srcPort_reg}, wb_dat_i, wb_sel_i);

  // header on the datagram dual-port debug path only
  wire hdrOn = applied_reg[`TMS_CFG_SRCHDR] & applied_reg[`TMS_CFG_DBGDP];

  // ==========================================================================
  // target read synchroniser
  reg rdS1, rdS2, rdS3, rdState;
  reg [9:0] addrS1, addrS2;
  wire readEv = rdState & ~rdS2 & ~rdS3;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdS1 <= 1'b1;
      rdS2 <= 1'b1;
      rdS3 <= 1'b1;
      rdState <= 1'b1;
      addrS1 <= 10'h000;
      addrS2 <= 10'h000;
    end else begin
      rdS1 <= tgtReadN;
      rdS2 <= rdS1;
      rdS3 <= rdS2;
      addrS1 <= tgtAddr;
      addrS2 <= addrS1;
      if (rdS2 == rdS3) begin
        rdState <= rdS3;
      end
    end
  end

  // ==========================================================================
  // read counting and byte decode
  reg [2:0] rdCnt_reg;
  reg [9:0] lastAddr_reg;
  reg [1:0] msCnt_reg;
  reg [15:0] msAddr_reg;
  reg [2:0] hdrRxCnt_reg;
  reg ackEv;
  wire [2:0] raCount = (applied_reg[`TMS_CFG_RACNT] == 3'h0) ? 3'h1 :
                       applied_reg[`TMS_CFG_RACNT];
  wire [2:0] rdCntInc = ((addrS2 == lastAddr_reg) && (rdCnt_reg != 3'h0)) ?
                        rdCnt_reg + 3'h1 : 3'h1;
  wire byteEv = readEv && (rdCntInc == raCount);
  wire [7:0] byteVal = addrS2[7:0];
  wire [1:0] region = addrS2[`TMS_AREA_REGION];
  wire memSetEn = applied_reg[`TMS_CFG_WREQ] | applied_reg[`TMS_CFG_CONSRA] |
                  applied_reg[`TMS_CFG_DBGRA];
  wire consEv = byteEv && (region == `TMS_AREA_CONS) && applied_reg[`TMS_CFG_CONSRA];
  wire dbgEv = byteEv && (region == `TMS_AREA_DBG) && applied_reg[`TMS_CFG_DBGRA];
  wire msEv = byteEv && (region == `TMS_AREA_MEMSET) && memSetEn;
  wire ctlEv = byteEv && (region == `TMS_AREA_CTRL);
  wire sopEv = ctlEv && (byteVal == `TMS_CTRL_SOP);
  wire hdrByte = dbgEv && hdrOn && (hdrRxCnt_reg != 3'h0);
  wire hdrDone = hdrByte && (hdrRxCnt_reg == 3'h1);
  wire rxEv = consEv | (dbgEv & ~hdrByte);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdCnt_reg <= 3'h0;
      lastAddr_reg <= 10'h000;
      msCnt_reg <= 2'h0;
      msAddr_reg <= 16'h0000;
      hdrRxCnt_reg <= 3'h0;
      rxData_reg <= 8'h00;
      dstAddr_reg <= 32'h00000000;
      dstPort_reg <= 16'h0000;
      emuWrStb <= 1'b0;
      emuWrAddr <= 16'h0000;
      emuWrData <= 8'h00;
      ackEv <= 1'b0;
    end else begin
      emuWrStb <= 1'b0;
      ackEv <= ctlEv && (byteVal == `TMS_CTRL_ACK);
      if (tgtRstCmd) begin
        rdCnt_reg <= 3'h0;
        msCnt_reg <= 2'h0;
        hdrRxCnt_reg <= 3'h0;
      end else begin
        if (readEv) begin
          lastAddr_reg <= addrS2;
          rdCnt_reg <= byteEv ? 3'h0 : rdCntInc;
        end
        if (rxEv) begin
          rxData_reg <= byteVal;
        end
        // memory set: address high, address low, value
        if (msEv) begin
          if (msCnt_reg == `TMS_MEMSET_BYTES - 2'h1) begin
            msCnt_reg <= 2'h0;
            emuWrStb <= 1'b1;
            emuWrAddr <= msAddr_reg;
            emuWrData <= byteVal;
          end else begin
            msCnt_reg <= msCnt_reg + 2'h1;
            msAddr_reg <= {msAddr_reg[7:0], byteVal};
          end
        end
        // incoming header: address then port, most significant byte first
        if (sopEv && hdrOn) begin
          hdrRxCnt_reg <= `TMS_HDR_BYTES;
        end else if (hdrByte) begin
          hdrRxCnt_reg <= hdrRxCnt_reg - 3'h1;
          if (hdrRxCnt_reg > 3'h2) begin
            dstAddr_reg <= {dstAddr_reg[23:0], byteVal};
          end else begin
            dstPort_reg <= {dstPort_reg[7:0], byteVal};
          end
        end
      end
    end
  end

  // ==========================================================================
  // outgoing mailbox stream with source header
  reg [47:0] hdrShift_reg;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hdrTxCnt_reg <= 3'h0;
      hdrShift_reg <= 48'h000000000000;
      mbxData <= 8'h00;
      mbxValid <= 1'b0;
    end else begin
      mbxValid <= 1'b0;
      if (hdrTxCnt_reg != 3'h0) begin
        mbxValid <= 1'b1;
        mbxData <= hdrShift_reg[47:40];
        hdrShift_reg <= {hdrShift_reg[39:0], 8'h00};
        hdrTxCnt_reg <= hdrTxCnt_reg - 3'h1;
      end else if (pktStart && hdrOn) begin
        hdrTxCnt_reg <= `TMS_HDR_BYTES;
        hdrShift_reg <= {srcAddr_reg, srcPort_reg};
      end else if (txWr) begin
        mbxValid <= 1'b1;
        mbxData <= wb_dat_i[7:0];
      end
    end
  end

  // ==========================================================================
  // target reset and applied settings
  reg [31:0] rstCnt_reg;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      applied_reg <= `TMS_CFG_RST;
      rstCnt_reg <= 32'h00000000;
      tgtRstOe <= 1'b0;
      tgtRstOut <= 1'b0;
    end else begin
      tgtRstOut <= 1'b0;
      if (tgtRstCmd) begin
        applied_reg <= cfg_reg;
        rstCnt_reg <= RST_CYCLES[31:0];
        tgtRstOe <= 1'b1;
      end else if (rstCnt_reg != 32'h00000000) begin
        rstCnt_reg <= rstCnt_reg - 32'h00000001;
        tgtRstOe <= (rstCnt_reg != 32'h00000001);
      end
    end
  end

  // ==========================================================================
  // control output
  reg [31:0] tickCnt_reg;
  reg [15:0] stepCnt_reg;
  reg phase_reg;
  reg shotOn_reg;
  reg awaitAck_reg;
  wire tick = (tickCnt_reg == TICK_CYCLES[31:0] - 32'h00000001);
  wire [1:0] mode = sigCtl_reg[`TMS_SIG_MODE];
  wire level = sigCtl_reg[`TMS_SIG_LEVEL];
  wire dataPlaced = txWr | notifyCmd;
  wire drFire = (mode == `TMS_MODE_DREADY) && dataPlaced &&
                ~(sigCtl_reg[`TMS_SIG_ACKGATE] & awaitAck_reg);
  wire periodicRun = (mode == `TMS_MODE_PERIODIC) && (steps_reg != 16'h0000);
  reg assertNext;
  always @* begin
    case (mode)
      `TMS_MODE_PERIODIC: assertNext = periodicRun ? (phase_reg ? ~level : level) : level;
      `TMS_MODE_PULSE: assertNext = shotOn_reg ? level : ~level;
      `TMS_MODE_DREADY: assertNext = shotOn_reg ? level : ~level;
      default: assertNext = level;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt_reg <= 32'h00000000;
      stepCnt_reg <= 16'h0000;
      phase_reg <= 1'b0;
      shotOn_reg <= 1'b0;
      awaitAck_reg <= 1'b0;
      ctlOe <= 1'b0;
      ctlOut <= 1'b0;
    end else begin
      ctlOut <= 1'b0;
      ctlOe <= assertNext;
      if (sigWr || drFire || tick) begin
        tickCnt_reg <= 32'h00000000;
      end else begin
        tickCnt_reg <= tickCnt_reg + 32'h00000001;
      end
      if (sigWr) begin
        stepCnt_reg <= 16'h0000;
        phase_reg <= 1'b0;
        shotOn_reg <= (sigNext[`TMS_SIG_MODE] == `TMS_MODE_PULSE);
        awaitAck_reg <= 1'b0;
      end else begin
        if (ackEv) begin
          awaitAck_reg <= 1'b0;
        end
        // a new fire wins over an ack in the same cycle
        if (drFire) begin
          shotOn_reg <= 1'b1;
          awaitAck_reg <= 1'b1;
        end else if (tick) begin
          shotOn_reg <= 1'b0;
        end
        if (tick && periodicRun) begin
          if (stepCnt_reg == steps_reg - 16'h0001) begin
            stepCnt_reg <= 16'h0000;
            phase_reg <= ~phase_reg;
          end else begin
            stepCnt_reg <= stepCnt_reg + 16'h0001;
          end
        end
      end
    end
  end

  // ==========================================================================
  // wishbone register file and interrupts
  wire [`TMS_IRQ_W-1:0] irqSet = {hdrDone, ackEv, emuWrStb, rxEv};
  reg [`TMS_IRQ_W-1:0] irqClr;
  reg [31:0] rdMux;
  always @* begin
    irqClr = {`TMS_IRQ_W{1'b0}};
    if (wrTake && (wb_adr_i == `TMS_REG_IRQSTAT) && wb_sel_i[0]) begin
      irqClr = wb_dat_i[`TMS_IRQ_W-1:0];
    end
    case (wb_adr_i)
      `TMS_REG_CFG: rdMux = {24'h000000, cfg_reg};
      `TMS_REG_APPLIED: rdMux = {24'h000000, applied_reg};
      `TMS_REG_SIGCTL: rdMux = sigCtl_reg;
      `TMS_REG_SRCADDR: rdMux = srcAddr_reg;
      `TMS_REG_SRCPORT: rdMux = {16'h0000, srcPort_reg};
      `TMS_REG_RXDATA: rdMux = {24'h000000, rxData_reg};
      `TMS_REG_DSTADDR: rdMux = dstAddr_reg;
      `TMS_REG_DSTPORT: rdMux = {16'h0000, dstPort_reg};
      `TMS_REG_MEMSET: rdMux = {8'h00, emuWrAddr, emuWrData};
      `TMS_REG_IRQSTAT: rdMux = {28'h0000000, irqStat_reg};
      `TMS_REG_IRQMASK: rdMux = {28'h0000000, irqMask_reg};
      default: rdMux = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      cfg_reg <= `TMS_CFG_RST;
      sigCtl_reg <= 32'h00000000;
      steps_reg <= 16'h0000;
      srcAddr_reg <= 32'h00000000;
      srcPort_reg <= 16'h0000;
      irqStat_reg <= {`TMS_IRQ_W{1'b0}};
      irqMask_reg <= {`TMS_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      wb_ack_o <= wbTake;
      if (wbTake && !wb_we_i) begin
        wb_dat_o <= rdMux;
      end
      // set wins over a clear in the same cycle
      irqStat_reg <= (irqStat_reg & ~irqClr) | irqSet;
      irq <= |(((irqStat_reg & ~irqClr) | irqSet) & irqMask_reg);
      if (wrTake) begin
        case (wb_adr_i)
          `TMS_REG_CFG: cfg_reg <= cfgMerge[`TMS_CFG_W-1:0];
          `TMS_REG_SIGCTL: begin
            sigCtl_reg <= sigNext;
            steps_reg <= msToSteps(sigNext[`TMS_SIG_IVAL]);
          end
          `TMS_REG_SRCADDR: srcAddr_reg <= byteMerge(srcAddr_reg, wb_dat_i, wb_sel_i);
          `TMS_REG_SRCPORT: srcPort_reg <= portMerge[15:0];
          `TMS_REG_IRQMASK: irqMask_reg <= wb_sel_i[0] ? wb_dat_i[`TMS_IRQ_W-1:0] :
                                           irqMask_reg;
          default: cfg_reg <= cfg_reg;
        endcase
      end
    end
  end

endmodule
